// [hw/xfer_pkg.sv]
// shared constants and carrier types for the extended-store transfer sequencer
package xfer_pkg;
    localparam int CORE_CLK_MHZ = 250;
    localparam int PERIOD_NS = 100;
    localparam int PERIOD_CYC = PERIOD_NS * CORE_CLK_MHZ / 1000;
    localparam int PH_W = 5;
    localparam logic [PH_W-1:0] PH_EARLY = 5'h00;
    localparam logic [PH_W-1:0] PH_LATE = 5'(PERIOD_CYC / 2);
    localparam logic [PH_W-1:0] PH_LAST = 5'(PERIOD_CYC - 1);
    localparam int SHIFT_NS = 300;
    localparam int SHIFT_STAGES = SHIFT_NS / PERIOD_NS;
    localparam int READ_CHAIN_NS = 1100;
    localparam int READ_EXTRA_NS = 200;
    localparam int READ_STAGES = (READ_CHAIN_NS + READ_EXTRA_NS) / PERIOD_NS;
    localparam int DATA_W = 60;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 18;
    localparam logic [2:0] REC_RESET = 3'h0;
    localparam logic [3:0] PROG_RESET = 4'h0;
    localparam logic [3:0] PROG_MAX = 4'hf;
    localparam logic [3:0] PROG_BEFORE_TWO = 4'h1;
    localparam logic [3:0] PROG_BEFORE_SEVEN = 4'h6;

    typedef struct packed {
        logic accept;
        logic abort;
    } resp_s;

    typedef struct packed {
        logic cont_req;
        logic bank_init;
    } mem_strobe_s;
endpackage

// [hw/period_shift.sv]
// shift register of whole clock periods, stepped once per period
module period_shift #(
    parameter int DEPTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic din,
    output logic dout
);
    logic [DEPTH-1:0] sr_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            sr_r <= '0;
        end else if (step) begin
            if (DEPTH > 1) begin
                sr_r <= {sr_r[DEPTH-2:0], din};
            end else begin
                sr_r[0] <= din;
            end
        end
    end

    assign dout = sr_r[DEPTH-1];
endmodule

// [hw/word_fifo.sv]
// first-in first-out word buffer with registered ready toward the filler
module word_fifo #(
    parameter int WIDTH = 60,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic push;
    logic pop;

    assign push = in_valid & ready_r;
    assign pop = out_valid & out_ready;
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rd_ptr_r];
    assign in_ready = ready_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (push & !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop & !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            // registered so the filler sees a clean level; full is exact, not early
            ready_r <= cnt_nxt != FULL_CNT;
        end
    end
endmodule

// [hw/xfer_seq.sv]
// transfer sequencer: response capture, run control, memory strobes, record and progress counters
//
// Behaviour
// - far controller accepts per record and when ready; accept is captured and fanned out
// - run sets on captured accept, no stop-run, no flag-register operation; run gates transfers
// - captured abort goes to error and break-in; write ends at once, read completes
// - write mode: run sets the 300 ns shift register and continue-request at early phase
// - continue-request reserves a memory bank 400 ns before each bank-initiate
// - shift register output sets bank-initiate at the following late phase
// - the 100 ns square wave latches bank-initiate out toward central memory
// - read mode: run passes 1100 ns chain plus two 100 ns stages first
// - read mode: at least 1700 ns from run to bank-initiate at memory
// - once words move, at most one word every 100 ns; a stalled far side pauses them
// - record preset is low address bits, or remaining count minus one on last record
// - counter presets when idle; run sets one-shot at early/late phase, then decrements
// - record count zero drops run; new accept needed; counter returns to preset
// - progress counter clears on decrement entry, increments at each late phase
// - write mode: progress two sets write-block request once until end of transfer
// - progress two resets the request flip-flop for the next request
// - progress seven with substitute-read sets run to finish zero words
// - substitute-read starts on read abort, ends at remaining zero, dropping run
module xfer_seq
    import xfer_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic XS_ACCEPT,
    input wire logic XS_ABORT,
    input wire logic WRITE_MODE,
    input wire logic STOP_RUN,
    input wire logic FLAG_OP,
    input wire logic END_XFER,
    input wire logic [2:0] LOW_ADDR,
    input wire logic [CNT_W-1:0] REMAIN_COUNT,
    input wire logic MEM_VALID,
    output logic MEM_READY,
    input wire logic [DATA_W-1:0] MEM_DATA,
    output logic XS_VALID,
    input wire logic XS_READY,
    output logic [DATA_W-1:0] XS_DATA,
    output resp_s RESP_OUT,
    output logic ABORT_TO_ERR,
    output logic ABORT_TO_BREAK,
    output logic RUN,
    output mem_strobe_s MEM_STROBE,
    output logic WR_BLOCK_REQ,
    output logic REQ_PENDING,
    output logic SUB_READ,
    output logic [2:0] RECORD_WORDS,
    output logic [3:0] WORD_PROGRESS
);
    function automatic logic [2:0] preset_sel(input logic [2:0] addr, input logic [CNT_W-1:0] remain);
        logic [CNT_W-1:0] addr_w;
        logic [CNT_W-1:0] rem_m1;
        addr_w = {{(CNT_W - 3){1'b0}}, addr};
        rem_m1 = remain - 1'b1;
        if (remain <= addr_w) begin
            preset_sel = rem_m1[2:0];
        end else begin
            preset_sel = addr;
        end
    endfunction

    // both phase strobes decode the same counter against a fixed mark
    function automatic logic at_phase(input logic [PH_W-1:0] ph, input logic [PH_W-1:0] mark);
        at_phase = ph == mark;
    endfunction

    logic [PH_W-1:0] ph_r;
    logic early_phase;
    logic late_phase;
    logic square_wave;
    resp_s resp_r;
    logic accept_d_r;
    logic accept_edge;
    logic run_r;
    logic run_set;
    logic run_clr;
    logic dec_r;
    logic dec_set;
    logic [2:0] rec_r;
    logic [3:0] prog_r;
    logic prog_step;
    logic prog_hit_two;
    logic prog_hit_seven;
    logic rec_zero;
    logic remain_zero;
    logic sub_r;
    logic sub_hold;
    logic wr_blk_r;
    logic req_r;
    logic read_go;
    logic read_out;
    logic launch;
    logic shift_out;
    logic cont_r;
    logic bank_ff_r;
    logic bank_out_r;
    logic fifo_valid;
    logic fifo_ready;
    logic [DATA_W-1:0] fifo_data;
    logic xs_valid_r;
    logic [DATA_W-1:0] xs_data_r;
    logic pop;

    // one 100 ns period: early phase at its start, late phase halfway
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ph_r <= PH_EARLY;
        end else if (ph_r == PH_LAST) begin
            ph_r <= PH_EARLY;
        end else begin
            ph_r <= ph_r + 1'b1;
        end
    end

    assign early_phase = at_phase(ph_r, PH_EARLY);
    assign late_phase = at_phase(ph_r, PH_LATE);
    assign square_wave = ph_r < PH_LATE;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            resp_r <= '0;
            accept_d_r <= 1'b0;
        end else begin
            resp_r.accept <= XS_ACCEPT;
            resp_r.abort <= XS_ABORT;
            accept_d_r <= resp_r.accept;
        end
    end

    // a held accept must not re-arm run after a record ends
    assign accept_edge = resp_r.accept & !accept_d_r;
    assign rec_zero = dec_r & early_phase & (rec_r == REC_RESET);
    assign remain_zero = REMAIN_COUNT == '0;
    // once seven words have counted under substitute-read, a record end must not stop the zero fill
    assign sub_hold = sub_r & (prog_r > PROG_BEFORE_SEVEN);

    // set and clear terms kept apart; set has priority in the flip-flop below
    always_comb begin
        run_set = 1'b0;
        run_clr = 1'b0;
        if (accept_edge & !STOP_RUN & !FLAG_OP) begin
            run_set = 1'b1;
        end
        if (prog_hit_seven & sub_r) begin
            run_set = 1'b1;
        end
        if (rec_zero & !sub_hold) begin
            run_clr = 1'b1;
        end
        if (resp_r.abort & WRITE_MODE) begin
            run_clr = 1'b1;
        end
        if (sub_r & remain_zero) begin
            run_clr = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            run_r <= 1'b0;
        end else if (run_set) begin
            run_r <= 1'b1;
        end else if (run_clr) begin
            run_r <= 1'b0;
        end
    end

    // the one-shot fires at the first early or late phase after run rises
    always_comb begin
        dec_set = 1'b0;
        if (run_r & !dec_r) begin
            dec_set = early_phase | late_phase;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            dec_r <= 1'b0;
        end else if (!run_r) begin
            dec_r <= 1'b0;
        end else if (dec_set) begin
            dec_r <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rec_r <= REC_RESET;
        end else if (!dec_r) begin
            rec_r <= preset_sel(LOW_ADDR, REMAIN_COUNT);
        end else if (early_phase && rec_r != REC_RESET) begin
            rec_r <= rec_r - 3'h1;
        end
    end

    // the progress counter keeps stepping under substitute-read so seven can be reached
    always_comb begin
        prog_step = 1'b0;
        if (late_phase & !dec_set) begin
            prog_step = dec_r | sub_r;
        end
    end
    assign prog_hit_two = prog_step & (prog_r == PROG_BEFORE_TWO);
    assign prog_hit_seven = prog_step & (prog_r == PROG_BEFORE_SEVEN);

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            prog_r <= PROG_RESET;
        end else if (dec_set) begin
            prog_r <= PROG_RESET;
        end else if (prog_step && prog_r != PROG_MAX) begin
            prog_r <= prog_r + 4'h1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            wr_blk_r <= 1'b0;
        end else if (prog_hit_two & WRITE_MODE) begin
            wr_blk_r <= 1'b1;
        end else if (END_XFER) begin
            wr_blk_r <= 1'b0;
        end
    end

    // request pending from each accepted record until two words have moved
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            req_r <= 1'b0;
        end else if (dec_set) begin
            req_r <= 1'b1;
        end else if (prog_hit_two) begin
            req_r <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sub_r <= 1'b0;
        end else if (resp_r.abort & !WRITE_MODE & !remain_zero) begin
            sub_r <= 1'b1;
        end else if (remain_zero) begin
            sub_r <= 1'b0;
        end
    end

    assign read_go = run_r & !WRITE_MODE;

    period_shift #(
        .DEPTH(READ_STAGES)
    ) u_read_delay (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .step(early_phase),
        .din(read_go),
        .dout(read_out)
    );

    // write launches straight away; read waits for the fetch delay
    always_comb begin
        if (WRITE_MODE) begin
            launch = run_r;
        end else begin
            launch = read_out & read_go;
        end
    end

    // the stage loaded with continue-request is its own period, so one extra stage gives 400 ns in all
    period_shift #(
        .DEPTH(SHIFT_STAGES + 1)
    ) u_bank_delay (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .step(early_phase),
        .din(launch),
        .dout(shift_out)
    );

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cont_r <= 1'b0;
        end else if (early_phase & launch) begin
            cont_r <= 1'b1;
        end else if (late_phase) begin
            cont_r <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            bank_ff_r <= 1'b0;
        end else if (late_phase) begin
            bank_ff_r <= shift_out;
        end
    end

    // output latch follows the square wave's rising edge, half a period after late phase
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            bank_out_r <= 1'b0;
        end else if (early_phase & square_wave) begin
            bank_out_r <= bank_ff_r;
        end
    end

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .in_valid(MEM_VALID),
        .in_ready(fifo_ready),
        .in_data(MEM_DATA),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // at most one word per period; a stalled far side holds the word and fills the buffer
    always_comb begin
        pop = 1'b0;
        if (early_phase & run_r & WRITE_MODE & fifo_valid) begin
            pop = !xs_valid_r | XS_READY;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            xs_valid_r <= 1'b0;
            xs_data_r <= '0;
        end else if (pop) begin
            xs_valid_r <= 1'b1;
            xs_data_r <= fifo_data;
        end else if (XS_READY) begin
            xs_valid_r <= 1'b0;
        end
    end

    assign MEM_READY = fifo_ready;
    assign XS_VALID = xs_valid_r;
    assign XS_DATA = xs_data_r;
    assign RESP_OUT = resp_r;
    assign ABORT_TO_ERR = resp_r.abort;
    assign ABORT_TO_BREAK = resp_r.abort;
    assign RUN = run_r;
    assign MEM_STROBE.cont_req = cont_r;
    assign MEM_STROBE.bank_init = bank_out_r;
    assign WR_BLOCK_REQ = wr_blk_r;
    assign REQ_PENDING = req_r;
    assign SUB_READ = sub_r;
    assign RECORD_WORDS = rec_r;
    assign WORD_PROGRESS = prog_r;
endmodule

// [test/xfer_seq_assertions.sv]
// port-level checks for the transfer sequencer
module xfer_seq_assertions
    import xfer_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic XS_ACCEPT,
    input wire logic XS_ABORT,
    input wire logic WRITE_MODE,
    input wire logic STOP_RUN,
    input wire logic FLAG_OP,
    input wire resp_s RESP_OUT,
    input wire logic RUN,
    input wire mem_strobe_s MEM_STROBE,
    input wire logic WR_BLOCK_REQ,
    input wire logic REQ_PENDING,
    input wire logic SUB_READ,
    input wire logic [2:0] RECORD_WORDS,
    input wire logic [3:0] WORD_PROGRESS
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q;
    logic [9:0] rd_cnt;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    always_ff @(posedge CORE_CLK) begin
        run_q <= RUN;
    end
    // cycles since run last rose, held at the top so it never wraps
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) rd_cnt <= 10'h000;
        else if (RUN && !run_q) rd_cnt <= 10'h001;
        else if (rd_cnt != 10'h3ff) rd_cnt <= rd_cnt + 10'h001;
    end
    chk_run_set: assert property ($rose(XS_ACCEPT) && !STOP_RUN && !FLAG_OP ##1 !STOP_RUN && !FLAG_OP |=> RUN)
        else $error("run not set by accept");
    chk_run_block: assert property ((STOP_RUN || FLAG_OP) && !RUN && !SUB_READ |=> !RUN)
        else $error("run set while blocked");
    chk_resp_cap: assert property (RESP_OUT == $past({XS_ACCEPT, XS_ABORT}))
        else $error("response not captured");
    chk_wr_abort: assert property (WRITE_MODE && $rose(XS_ABORT) && !XS_ACCEPT ##1 !XS_ACCEPT |=> !RUN)
        else $error("write abort kept run");
    chk_cont_len: assert property ($rose(MEM_STROBE.cont_req) |-> ##11 MEM_STROBE.cont_req ##1 !MEM_STROBE.cont_req)
        else $error("continue request width wrong");
    chk_bank_lead: assert property (WRITE_MODE && $rose(MEM_STROBE.cont_req) |-> ##100 MEM_STROBE.bank_init)
        else $error("bank initiate not 400 ns after request");
    chk_read_wait: assert property (!WRITE_MODE && $rose(MEM_STROBE.bank_init) |-> rd_cnt >= 10'h1a9)
        else $error("read bank initiate too early");
    chk_prog_step: assert property ($changed(WORD_PROGRESS) && WORD_PROGRESS != 4'h0
        |-> WORD_PROGRESS == $past(WORD_PROGRESS) + 4'h1)
        else $error("progress stepped wrongly");
    chk_wr_block: assert property (WRITE_MODE && $changed(WORD_PROGRESS) && WORD_PROGRESS == 4'h2
        |-> ##[0:1] WR_BLOCK_REQ)
        else $error("write block request not set");
    chk_req_clear: assert property ($changed(WORD_PROGRESS) && WORD_PROGRESS == 4'h2 |-> ##[0:1] !REQ_PENDING)
        else $error("request flop not reset");
    chk_run_drop: assert property ($fell(RUN) |-> $past(RECORD_WORDS) == 3'h0 || $past(RESP_OUT.abort) || $past(SUB_READ))
        else $error("run dropped without cause");
endmodule

bind xfer_seq xfer_seq_assertions i_xfer_seq_assertions (.*);

// [test/xs_far_model.sv]
// far storage controller model: record accepts, abort, paced word sink
module xs_far_model (
    input wire logic CORE_CLK,
    input wire logic kick,
    input wire logic fail,
    input wire logic slow,
    output logic XS_ACCEPT = 1'b0,
    output logic XS_ABORT = 1'b0,
    output logic XS_READY = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pace_r = 2'h0;
    // accept is a one-cycle event; holding it would not start another record
    always @(posedge CORE_CLK) XS_ACCEPT <= kick;
    always @(posedge CORE_CLK) XS_ABORT <= fail;
    // slow mode stalls two cycles in three so a word must be held
    always @(posedge CORE_CLK) begin
        pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
        XS_READY <= !slow || pace_r == 2'h0;
    end
endmodule

// [test/xfer_seq_bench.sv]
// self-checking bench for the transfer sequencer against a far controller model
module xfer_seq_bench
    import xfer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 1'b0, SYS_RST = 1'b1, WRITE_MODE = 1'b1, STOP_RUN = 1'b0, FLAG_OP = 1'b0;
    logic END_XFER = 1'b0, MEM_VALID = 1'b0, kick = 1'b0, fail = 1'b0, slow = 1'b0;
    logic [2:0] LOW_ADDR = 3'h7;
    logic [CNT_W-1:0] REMAIN_COUNT = 18'h00100;
    logic [DATA_W-1:0] MEM_DATA = '0;
    logic XS_ACCEPT, XS_ABORT, XS_READY, MEM_READY, XS_VALID, ABORT_TO_ERR, ABORT_TO_BREAK, RUN;
    logic WR_BLOCK_REQ, REQ_PENDING, SUB_READ;
    logic [DATA_W-1:0] XS_DATA;
    logic [2:0] RECORD_WORDS;
    logic [3:0] WORD_PROGRESS;
    resp_s RESP_OUT;
    mem_strobe_s MEM_STROBE;
    logic [DATA_W-1:0] exp_q[$];
    int miscompares = 0, check_count = 0, n, i;
    xfer_seq i_xfer_seq (.*);
    xs_far_model i_xs_far_model (.*);
    initial forever #2 CORE_CLK = ~CORE_CLK;
    task automatic cmp_flag(input logic got, input logic want);
        check_count++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %0t flag %b not %b", $time, got, want);
        end
    endtask
    task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
        check_count++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %0t word %h not %h", $time, got, want);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic give_up();
        miscompares++;
        $display("[FAIL] %0t wait bound used up", $time);
        results();
    endtask
    // k returns the edges waited so callers can judge timing
    task automatic wait_run(input logic lvl, output int k);
        k = 0;
        while (RUN !== lvl && k < 3000) begin
            @(posedge CORE_CLK);
            k++;
        end
        if (RUN !== lvl) give_up();
    endtask
    task automatic accept();
        kick <= 1'b1;
        @(posedge CORE_CLK);
        kick <= 1'b0;
    endtask
    task automatic push(input logic [DATA_W-1:0] w);
        int k = 0;
        MEM_VALID <= 1'b1;
        MEM_DATA <= w;
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (MEM_READY !== 1'b1 && k < 500);
        if (MEM_READY !== 1'b1) give_up();
        exp_q.push_back(w);
    endtask
    function automatic logic [2:0] preset(input logic [2:0] l, input logic [CNT_W-1:0] r);
        return (r <= CNT_W'(l)) ? 3'(r - CNT_W'(1)) : l;
    endfunction
    // every word leaving toward the far side must be the oldest one buffered
    always @(posedge CORE_CLK) begin
        if (XS_VALID && XS_READY && !SYS_RST)
            cmp_word(XS_DATA, exp_q.size() > 0 ? exp_q.pop_front() : '1);
    end
    initial begin
        logic [2:0] l;
        logic [CNT_W-1:0] r;
        void'($urandom(76));
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        @(posedge CORE_CLK);
        #1;
        cmp_flag(MEM_READY, 1'b1);
        cmp_word(DATA_W'({RUN, MEM_STROBE, WORD_PROGRESS, WR_BLOCK_REQ, SUB_READ}), '0);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            l = (i == 0) ? 3'h7 : 3'($urandom);
            r = (i == 0) ? 18'h00007 : (i == 1) ? CNT_W'(l) + 18'h00001 : CNT_W'($urandom_range(1, 10));
            @(posedge CORE_CLK);
            LOW_ADDR <= l;
            REMAIN_COUNT <= r;
            repeat (3) @(posedge CORE_CLK);
            #1 cmp_word(DATA_W'(RECORD_WORDS), DATA_W'(preset(l, r)));
        end
        @(posedge CORE_CLK);
        LOW_ADDR <= 3'h7;
        REMAIN_COUNT <= 18'h00100;
        $display("preset test done");
        for (i = 0; i < 2; i++) begin
            STOP_RUN <= (i == 0);
            FLAG_OP <= (i == 1);
            accept();
            repeat (6) @(posedge CORE_CLK);
            cmp_flag(RUN, 1'b0);
        end
        STOP_RUN <= 1'b0;
        FLAG_OP <= 1'b0;
        slow <= 1'b1;
        $display("block test done");
        for (i = 0; i < FIFO_DEPTH; i++) push(DATA_W'({$urandom, $urandom}));
        MEM_VALID <= 1'b0;
        @(posedge CORE_CLK);
        cmp_flag(MEM_READY, 1'b0);
        for (i = 0; i < 6 && exp_q.size() > 0; i++) begin
            accept();
            wait_run(1'b1, n);
            wait_run(1'b0, n);
            if (i == 0) cmp_flag(n > 175 && n < 230, 1'b1);
        end
        cmp_flag(exp_q.size() == 0, 1'b1);
        cmp_flag(WR_BLOCK_REQ, 1'b1);
        cmp_flag(REQ_PENDING, 1'b0);
        END_XFER <= 1'b1;
        @(posedge CORE_CLK);
        END_XFER <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        cmp_flag(WR_BLOCK_REQ, 1'b0);
        $display("write test done");
        accept();
        wait_run(1'b1, n);
        repeat (30) @(posedge CORE_CLK);
        fail <= 1'b1;
        wait_run(1'b0, n);
        cmp_flag(n < 5, 1'b1);
        cmp_flag(ABORT_TO_ERR && ABORT_TO_BREAK, 1'b1);
        fail <= 1'b0;
        $display("write abort test done");
        // a second reset also clears the read delay chain left from earlier runs
        SYS_RST <= 1'b1;
        WRITE_MODE <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        @(posedge CORE_CLK);
        accept();
        wait_run(1'b1, n);
        fail <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        fail <= 1'b0;
        cmp_flag(SUB_READ, 1'b1);
        cmp_flag(RUN, 1'b1);
        for (n = 4; MEM_STROBE.bank_init !== 1'b1 && n < 700; n++) @(posedge CORE_CLK);
        cmp_flag(n >= 425 && n < 700, 1'b1);
        REMAIN_COUNT <= 18'h00000;
        repeat (4) @(posedge CORE_CLK);
        cmp_flag(SUB_READ, 1'b0);
        cmp_flag(RUN, 1'b0);
        $display("read test done");
        results();
    end
endmodule
